// file: include/sap_pkg.sv
// package: constants, field layout and carriers of the sense averaging block
package sap_pkg;
	// rates and timing
	localparam int CLK_HZ = 10_000_000;
	localparam int MOD_HZ = 1_600_000;
	localparam logic [7:0] MOD_STEP = 8'(MOD_HZ / 100_000);
	localparam logic [7:0] MOD_WRAP = 8'(CLK_HZ / 100_000);
	localparam int DEC_LEN = 16;
	localparam int WIN_MS = 10;
	localparam int WIN_CYC_DEF = CLK_HZ / 1000 * WIN_MS;
	// converter channels
	localparam int NCH = 6;
	localparam int CH_VS1F = 0;
	localparam int CH_VS1 = 1;
	localparam int CH_VS2 = 2;
	localparam int CH_VS3 = 3;
	localparam int CH_CS1 = 4;
	localparam int CH_CS2 = 5;
	localparam int NVAL = 5;
	localparam int NTRIM = 3;
	localparam int TRIM_OF [NCH] = '{0, 0, 1, 2, 3, 3};
	localparam int NDEC = 3;
	localparam int DEC_CH [NDEC] = '{CH_VS1F, CH_VS1, CH_VS3};
	// register byte offsets
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STATUS = 8'h04;
	localparam logic [7:0] A_IRQ_STAT = 8'h08;
	localparam logic [7:0] A_IRQ_MASK = 8'h0C;
	localparam logic [7:0] A_SW_PERIOD = 8'h10;
	localparam logic [7:0] A_OCP_THR = 8'h14;
	localparam logic [7:0] A_TRIM0 = 8'h18;
	localparam logic [7:0] A_VAL0 = 8'h24;
	// control fields
	localparam int CTL_SHARE_DIG = 0;
	localparam int CTL_SHARE_LVL = 1;
	localparam int CTL_SRC_SW = 2;
	localparam int CTL_CS2_LO = 3;
	localparam int CTL_NVM_SAVE = 8;
	localparam logic [4:0] CTRL_RST = 5'h04;
	// secondary current range codes
	localparam logic [1:0] CS2_R37P5 = 2'h0;
	localparam logic [1:0] CS2_R75 = 2'h1;
	localparam logic [1:0] CS2_R150 = 2'h2;
	// flag bits
	localparam int FLAG_W = 9;
	localparam int FL_EXT = 8;
	localparam logic [8:0] PG1_MASK = 9'h07F;
	localparam logic [8:0] FAULT_MASK = 9'h0FF;
	// status fields above the flags
	localparam int ST_PG1 = 9;
	localparam int ST_PG2 = 10;
	localparam int ST_SON = 11;
	localparam int ST_SHFB = 12;
	localparam int ST_SRC = 13;
	localparam int ST_PG1_PIN = 14;
	localparam int ST_PG2_PIN = 15;
	// interrupt bits
	localparam int IRQ_W = 3;
	localparam int IRQ_WIN = 0;
	localparam int IRQ_PG1 = 1;
	localparam int IRQ_PG2 = 2;
	// reset values
	localparam logic [15:0] SW_PERIOD_RST = 16'h0064;
	localparam logic [11:0] OCP_THR_RST = 12'hFFF;

	typedef struct packed {
		logic [NCH-1:0][11:0] ch;
	} sap_samples_t;

	typedef struct packed {
		logic other;
		logic load_ovp;
		logic local_ovp;
		logic undervoltage_protect;
		logic cs2_acc_ocp;
		logic cs1_acc_ocp;
		logic supply_bad;
	} sap_faults_t;

	typedef struct packed {
		logic valid;
		logic src_local;
		logic [11:0] fast;
		logic [11:0] slow;
	} sap_loop_t;

	typedef struct packed {
		logic [NTRIM-1:0][11:0] vs;
	} sap_trim_t;
endpackage

// file: core/sap_dec16.sv
// sixteen-reading decimator feeding the control loop
`timescale 1ns/10ps
`default_nettype none
module sap_dec16 import sap_pkg::*; (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic tick,
	input wire logic [11:0] smp,
	output logic [11:0] avg_q,
	output logic done_q
);
	logic [15:0] acc_q;
	logic [3:0] cnt_q;
	logic [15:0] sum;
	logic [11:0] dec_next;

	assign sum = acc_q + {4'h0, smp};
	assign dec_next = sum[15:4];

	// sum sixteen readings, publish the mean on the last one
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			acc_q <= 16'h0000;
			cnt_q <= 4'h0;
			avg_q <= 12'h000;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (tick) begin
				cnt_q <= cnt_q + 4'h1;
				if (cnt_q == 4'(DEC_LEN - 1)) begin // see RULE_09
					avg_q <= dec_next;
					acc_q <= 16'h0000;
					done_q <= 1'b1;
				end else begin
					acc_q <= sum;
				end
			end
		end
	end

	chk_dec_sixteen: assert property (@(posedge sys_clk) disable iff (!rstn) // see RULE_09
		(tick && cnt_q == 4'hF) |=> (done_q && avg_q == $past(dec_next)))
		else $error("decimator result not the mean of sixteen readings");

	chk_dec_quiet: assert property (@(posedge sys_clk) disable iff (!rstn) // see RULE_09
		!tick |=> (!done_q && $stable(avg_q)))
		else $error("decimator changed without a modulator tick");

	chk_dec_count: assert property (@(posedge sys_clk) disable iff (!rstn) // see RULE_09
		tick |=> cnt_q == $past(cnt_q) + 4'h1)
		else $error("decimator missed a modulator reading");
endmodule
`default_nettype wire

// file: core/sap_avg.sv
// long-window averager for one monitoring value
`timescale 1ns/10ps
`default_nettype none
module sap_avg import sap_pkg::*; (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic tick,
	input wire logic [11:0] smp,
	input wire logic win_end,
	output logic [11:0] avg_q
);
	logic [31:0] sum_q;
	logic [23:0] cnt_q;
	logic [31:0] quot;

	assign quot = sum_q / {8'h00, cnt_q};

	// sum every reading, load the mean at window end
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			sum_q <= 32'h0000_0000;
			cnt_q <= 24'h00_0000;
			avg_q <= 12'h000;
		end else if (win_end) begin
			if (cnt_q != 24'h00_0000) begin
				avg_q <= quot[11:0]; // see RULE_10
			end
			sum_q <= tick ? {20'h0_0000, smp} : 32'h0000_0000;
			cnt_q <= tick ? 24'h00_0001 : 24'h00_0000;
		end else if (tick) begin
			sum_q <= sum_q + {20'h0_0000, smp};
			cnt_q <= cnt_q + 24'h00_0001;
		end
	end

	chk_avg_hold: assert property (@(posedge sys_clk) disable iff (!rstn) // see RULE_16
		!win_end |=> $stable(avg_q))
		else $error("averaged value changed between windows");

	chk_avg_load: assert property (@(posedge sys_clk) disable iff (!rstn) // see RULE_10
		(win_end && cnt_q != 24'h00_0000) |=> {20'h0_0000, avg_q} == $past(quot))
		else $error("window end did not load the mean");
endmodule
`default_nettype wire

// file: core/sap_top.sv
// sense averaging, loop source selection and power-good flags
//
// Function
// (RULE_01) the secondary power-good pin is asserted whenever any flag is set.
// (RULE_02) the primary power-good pin is asserted on supply, any overcurrent, uvp or ovp fault.
// (RULE_03) the external flag input raises its own flag.
// (RULE_04) in digital share mode the share bus output is driven as a digital pin.
// (RULE_05) the outside system drives supply_on_request to ask for turn-on.
// (RULE_06) the primary current feeds a peak comparator and an averaging converter.
// (RULE_07) the secondary current full-load drop selects 37.5, 75 or 150 mV.
// (RULE_08) one converter result goes to the loop per switching period.
// (RULE_09) modulators run at 1.6 MHz and each loop result is a mean of 16 readings.
// (RULE_10) voltage readings are averaged over 10 ms windows into value registers.
// (RULE_11) primary and secondary current readings are averaged the same way.
// (RULE_12) the fast loop input always comes from the fast first local sense converter.
// (RULE_13) the slow loop input is the remote point, moved local on soft start or fault.
// (RULE_14) every voltage point has a trim that can be stored in nonvolatile memory.
// (RULE_15) monitoring results are 12 bits, each in its own value register.
// (RULE_16) each value register holds steady until the next window ends.
`timescale 1ns/10ps
`default_nettype none
module sap_top import sap_pkg::*; #(
	parameter int WIN_CYC = WIN_CYC_DEF
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire sap_samples_t samples,
	input wire sap_faults_t faults,
	input wire logic soft_start,
	input wire logic external_flag_input,
	input wire logic supply_on_request,
	input wire logic share_bus_feedback,
	input wire logic share_bus_out_i,
	output logic share_bus_out_o,
	output logic share_bus_out_oe,
	input wire logic power_ok_primary_i,
	output logic power_ok_primary_o,
	output logic power_ok_primary_oe,
	input wire logic power_ok_secondary_i,
	output logic power_ok_secondary_o,
	output logic power_ok_secondary_oe,
	output sap_loop_t loop_q,
	output logic [1:0] cs2_range,
	input wire logic nvm_load,
	input wire sap_trim_t nvm_trim_in,
	output sap_trim_t nvm_trim,
	output logic nvm_save,
	output logic irq
);
	logic [4:0] ctrl_q;
	logic [15:0] sw_period_q;
	logic [11:0] ocp_thr_q;
	logic [IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_set;
	logic [FLAG_W-1:0] flags_q;
	logic cs1_fast_q, src_local_q, pg1_q, pg2_q, share_o_q;
	logic [7:0] mod_acc_q;
	logic [8:0] mod_nxt;
	logic mod_tick_q;
	logic [15:0] sw_cnt_q;
	logic sw_tick;
	logic [31:0] win_cnt_q;
	logic win_end_q;
	logic [NCH-1:0][11:0] tsmp;
	logic [NDEC-1:0][11:0] dec_avg;
	logic [NVAL-1:0][11:0] val;
	logic acc_ok, wr_pend_q, rd_clr;
	logic [7:0] wr_addr_q;
	logic [7:0] ra;
	logic [31:0] rd_d;

	// trim a reading with a signed offset, clamped to the 12-bit range
	function automatic logic [11:0] trim_add(input logic [11:0] s, input logic [11:0] t);
		logic signed [13:0] r;
		r = $signed({2'b00, s}) + $signed({{2{t[11]}}, t});
		if (r < 0) begin
			return 12'h000;
		end else if (r > 14'sh0FFF) begin
			return 12'hFFF;
		end
		return r[11:0];
	endfunction

	// ---- bus slave: zero wait, address captured, write in data phase
	assign acc_ok = hsel && htrans[1] && hready;
	assign ra = haddr[7:0];
	assign rd_clr = acc_ok && !hwrite && ra == A_IRQ_STAT;

	// read word of the addressed register, zero when unmapped
	always_comb begin
		rd_d = 32'h0000_0000;
		if (ra == A_CTRL) begin
			rd_d = {27'h0, ctrl_q};
		end else if (ra == A_STATUS) begin
			rd_d = {16'h0, power_ok_secondary_i, power_ok_primary_i, src_local_q,
				share_bus_feedback, supply_on_request, pg2_q, pg1_q, flags_q}; // see RULE_05
		end else if (ra == A_IRQ_STAT) begin
			rd_d = {29'h0, irq_stat_q};
		end else if (ra == A_IRQ_MASK) begin
			rd_d = {29'h0, irq_mask_q};
		end else if (ra == A_SW_PERIOD) begin
			rd_d = {16'h0, sw_period_q};
		end else if (ra == A_OCP_THR) begin
			rd_d = {20'h0, ocp_thr_q};
		end else if (ra >= A_TRIM0 && ra < A_VAL0 && ra[1:0] == 2'h0) begin
			rd_d = {20'h0, nvm_trim.vs[2'((ra - A_TRIM0) >> 2)]};
		end else if (ra >= A_VAL0 && ra < 8'(A_VAL0 + 4 * NVAL) && ra[1:0] == 2'h0) begin
			rd_d = {20'h0, val[3'((ra - A_VAL0) >> 2)]}; // see RULE_15
		end
	end

	// bus response and read data
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h0000_0000;
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= (acc_ok && !hwrite) ? rd_d : 32'h0000_0000;
			wr_pend_q <= acc_ok && hwrite;
			wr_addr_q <= ra;
		end
	end

	// software settings
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			ctrl_q <= CTRL_RST;
			sw_period_q <= SW_PERIOD_RST;
			ocp_thr_q <= OCP_THR_RST;
			irq_mask_q <= '0;
			nvm_save <= 1'b0;
		end else begin
			nvm_save <= 1'b0;
			if (wr_pend_q) begin
				if (wr_addr_q == A_CTRL) begin
					ctrl_q <= hwdata[4:0];
					nvm_save <= hwdata[CTL_NVM_SAVE]; // see RULE_14
				end else if (wr_addr_q == A_SW_PERIOD) begin
					sw_period_q <= hwdata[15:0];
				end else if (wr_addr_q == A_OCP_THR) begin
					ocp_thr_q <= hwdata[11:0];
				end else if (wr_addr_q == A_IRQ_MASK) begin
					irq_mask_q <= hwdata[IRQ_W-1:0];
				end
			end
		end
	end

	// voltage trims, written by software or loaded from nonvolatile memory
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			nvm_trim <= '0;
		end else if (nvm_load) begin
			nvm_trim <= nvm_trim_in; // see RULE_14
		end else if (wr_pend_q && wr_addr_q >= A_TRIM0 && wr_addr_q < A_VAL0) begin
			nvm_trim.vs[2'((wr_addr_q - A_TRIM0) >> 2)] <= hwdata[11:0];
		end
	end

	// secondary current range follows its control field, except code 3, which keeps the last range
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			cs2_range <= CS2_R37P5;
		end else if (ctrl_q[CTL_CS2_LO +: 2] != 2'h3) begin
			cs2_range <= ctrl_q[CTL_CS2_LO +: 2]; // see RULE_07
		end
	end

	// ---- modulator rate from a fractional divider
	assign mod_nxt = {1'b0, mod_acc_q} + {1'b0, MOD_STEP};
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			mod_acc_q <= 8'h00;
			mod_tick_q <= 1'b0;
		end else if (mod_nxt >= {1'b0, MOD_WRAP}) begin
			mod_acc_q <= 8'(mod_nxt - {1'b0, MOD_WRAP}); // see RULE_09
			mod_tick_q <= 1'b1;
		end else begin
			mod_acc_q <= mod_nxt[7:0];
			mod_tick_q <= 1'b0;
		end
	end

	// trimmed readings and loop decimators
	for (genvar c = 0; c < NCH; c++) begin : g_trim
		if (TRIM_OF[c] < NTRIM) begin : g_v
			assign tsmp[c] = trim_add(samples.ch[c], nvm_trim.vs[TRIM_OF[c]]); // see RULE_14
		end else begin : g_i
			assign tsmp[c] = samples.ch[c];
		end
	end

	for (genvar d = 0; d < NDEC; d++) begin : g_dec
		sap_dec16 u_dec (
			.sys_clk(sys_clk),
			.rstn(rstn),
			.tick(mod_tick_q),
			.smp(tsmp[DEC_CH[d]]),
			.avg_q(dec_avg[d]),
			.done_q()
		);
	end

	// ---- 10 ms monitoring window and value registers
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			win_cnt_q <= 32'h0000_0000;
			win_end_q <= 1'b0;
		end else if (win_cnt_q == 32'(WIN_CYC - 1)) begin
			win_cnt_q <= 32'h0000_0000;
			win_end_q <= 1'b1;
		end else begin
			win_cnt_q <= win_cnt_q + 32'h0000_0001;
			win_end_q <= 1'b0;
		end
	end

	for (genvar v = 0; v < NVAL; v++) begin : g_avg
		sap_avg u_avg (
			.sys_clk(sys_clk),
			.rstn(rstn),
			.tick(mod_tick_q),
			.smp(tsmp[v + 1]), // see RULE_10 RULE_11
			.win_end(win_end_q),
			.avg_q(val[v])
		);
	end

	// ---- switching period and loop hand-off
	assign sw_tick = ({1'b0, sw_cnt_q} + 17'h0_0001) >= {1'b0, sw_period_q};
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			sw_cnt_q <= 16'h0000;
		end else begin
			sw_cnt_q <= sw_tick ? 16'h0000 : sw_cnt_q + 16'h0001;
		end
	end

	// one result per period, fast input from the fast local converter
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			loop_q <= '0;
		end else begin
			loop_q.valid <= sw_tick; // see RULE_08
			loop_q.src_local <= src_local_q;
			if (sw_tick) begin
				loop_q.fast <= dec_avg[0]; // see RULE_12
				loop_q.slow <= src_local_q ? dec_avg[1] : dec_avg[2]; // see RULE_13
			end
		end
	end

	// slow regulation point moves local on soft start or any fault
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			src_local_q <= 1'b0;
		end else begin
			src_local_q <= ctrl_q[CTL_SRC_SW] && (soft_start || |(flags_q & FAULT_MASK)); // see RULE_13
		end
	end

	// ---- flags: peak comparator on primary current, fault levels, external flag
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			cs1_fast_q <= 1'b0;
		end else if (mod_tick_q) begin
			cs1_fast_q <= samples.ch[CH_CS1] >= ocp_thr_q; // see RULE_06
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			flags_q <= '0;
		end else begin
			flags_q <= {external_flag_input, faults.other, faults.load_ovp, faults.local_ovp,
				faults.undervoltage_protect, faults.cs2_acc_ocp, faults.cs1_acc_ocp, cs1_fast_q,
				faults.supply_bad}; // see RULE_03
		end
	end

	// power-good pins pull low while asserted; open-drain data levels are always low
	always_ff @(posedge sys_clk) begin
		power_ok_primary_o <= 1'b0;
		power_ok_secondary_o <= 1'b0;
		share_bus_out_o <= 1'b0;
		if (!rstn) begin
			pg1_q <= 1'b0;
			pg2_q <= 1'b0;
		end else begin
			pg1_q <= |(flags_q & PG1_MASK); // see RULE_02
			pg2_q <= |flags_q; // see RULE_01
		end
	end
	chk_pg_follow: assert property (@(posedge sys_clk) disable iff (!rstn) // see RULE_01 RULE_02
		pg2_q == |$past(flags_q) && pg1_q == |($past(flags_q) & PG1_MASK))
		else $error("power-good level does not follow the flags");

	assign power_ok_primary_oe = pg1_q;
	assign power_ok_secondary_oe = pg2_q;
	// digital share bus drives low for a zero level
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			share_o_q <= 1'b0;
		end else begin
			share_o_q <= ctrl_q[CTL_SHARE_DIG] && !ctrl_q[CTL_SHARE_LVL]; // see RULE_04
		end
	end

	assign share_bus_out_oe = share_o_q;

	// ---- interrupts: sticky, read clears, a new event wins
	assign irq_set = {|flags_q && !pg2_q, |(flags_q & PG1_MASK) && !pg1_q, win_end_q};
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			irq_stat_q <= {IRQ_W{1'b0}};
			irq <= 1'b0;
		end else begin
			irq_stat_q <= (rd_clr ? {IRQ_W{1'b0}} : irq_stat_q) | irq_set;
			irq <= |(irq_stat_q & irq_mask_q);
		end
	end
endmodule
`default_nettype wire

// file: test/sap_stage_model.sv
// model of the analogue power stage: sense readings, fault levels, control levels
`timescale 1ns/10ps
`default_nettype none
module sap_stage_model import sap_pkg::*; (
	input wire logic sys_clk,
	output sap_samples_t samples,
	output sap_faults_t faults,
	output logic soft_start,
	output logic external_flag_input,
	output logic supply_on_request
);
	// everything quiet until the bench sets a level
	initial begin
		samples = '0;
		faults = '0;
		soft_start = 1'b0;
		external_flag_input = 1'b0;
		supply_on_request = 1'b0;
	end
	// readings stay put between calls, as a settled converter input would
	task automatic set_ch(input int c, input logic [11:0] v);
		samples.ch[c] <= v;
	endtask
	task automatic set_flt(input logic [6:0] f);
		faults <= f;
	endtask
	// the turn-on request is the outside system's own level
	task automatic set_lvl(input logic ss, input logic ext, input logic son);
		soft_start <= ss;
		external_flag_input <= ext;
		supply_on_request <= son;
	endtask
endmodule
`default_nettype wire

// file: test/test_sense_averaging_power_good.sv
// self-checking bench of the sense averaging and power-good block
`timescale 1ns/10ps
`default_nettype none
module test_sense_averaging_power_good import sap_pkg::*; ;
	localparam int WC = 200;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic hsel = 1'b0, hwrite = 1'b0, rd_ph = 1'b0, nvm_load = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, v;
	logic [1:0] htrans = 2'h0, rng = 2'h0;
	logic [2:0] hsize = 3'h2;
	sap_trim_t nvm_trim_in = '0;
	wire logic hreadyout, hresp, irq, nvm_save, sh_oe, pg1_oe, pg2_oe;
	wire logic [31:0] hrdata;
	wire logic [1:0] cs2_range;
	wire sap_loop_t loop_q;
	wire sap_trim_t nvm_trim;
	wire sap_samples_t samples;
	wire sap_faults_t faults;
	wire logic soft_start, ext_flag, son;
	// open-drain pins with pull-ups; the share feedback is wired to the share pin
	wire logic sh_pin = !sh_oe;
	wire logic pg1_pin = !pg1_oe;
	wire logic pg2_pin = !pg2_oe;
	logic [63:0] expq[$];
	logic [63:0] ent;
	logic [11:0] s[NCH], p[NCH];
	int n_fail = 0, samples_checked = 0, n;
	integer seed = 32'h4B20;

	sap_stage_model m (.sys_clk(sys_clk), .samples(samples), .faults(faults),
		.soft_start(soft_start), .external_flag_input(ext_flag), .supply_on_request(son));

	sap_top #(.WIN_CYC(WC)) uut (.sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .samples(samples),
		.faults(faults), .soft_start(soft_start), .external_flag_input(ext_flag),
		.supply_on_request(son), .share_bus_feedback(sh_pin), .share_bus_out_i(sh_pin),
		.share_bus_out_o(), .share_bus_out_oe(sh_oe), .power_ok_primary_i(pg1_pin),
		.power_ok_primary_o(), .power_ok_primary_oe(pg1_oe),
		.power_ok_secondary_i(pg2_pin), .power_ok_secondary_o(),
		.power_ok_secondary_oe(pg2_oe), .loop_q(loop_q), .cs2_range(cs2_range),
		.nvm_load(nvm_load), .nvm_trim_in(nvm_trim_in), .nvm_trim(nvm_trim),
		.nvm_save(nvm_save), .irq(irq));

	// 10 MHz clock
	always #50 sys_clk = ~sys_clk;

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic fail(input logic [31:0] g, input logic [31:0] e);
		n_fail++;
		$display("[FAIL] %0t got %h expected %h", $time, g, e);
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) fail(g, e);
	endtask

	task automatic rdchk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) fail(g, e);
	endtask

	// observed pins, selected by number
	function automatic logic pin(input int k);
		case (k)
			0: return pg1_oe;
			1: return pg2_oe;
			2: return sh_oe;
			3: return irq;
			4: return nvm_save;
			default: return loop_q.valid;
		endcase
	endfunction

	// bounded wait for a pin level; a wait that runs out ends the run
	task automatic poll(input int k, input logic x, input int lim);
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pin(k) !== x && n < lim);
		chk(pin(k), x);
		if (pin(k) !== x) conclude();
	endtask

	task automatic rdy();
		int c;
		c = 0;
		do begin
			@(posedge sys_clk);
			c++;
		end while (hreadyout !== 1'b1 && c < 50);
		if (hreadyout !== 1'b1) begin
			fail(32'h0, 32'h1);
			conclude();
		end
	endtask

	// one single word transfer; reads leave their expectation in the queue
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] e, input logic [31:0] msk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		rdy();
		htrans <= 2'h0;
		hwdata <= d;
		rd_ph <= !w;
		if (!w) expq.push_back({e, msk});
		rdy();
		rd_ph <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 32'h0, 32'h0);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, e, 32'hFFFF_FFFF);
	endtask

	task automatic rdm(input logic [7:0] a, input int b, input logic x);
		bus(1'b0, a, 32'h0, 32'(x) << b, 32'h1 << b);
	endtask

	// the five value registers follow the channels after the fast one
	task automatic rdvals();
		for (int i = 0; i < NVAL; i++) rd(A_VAL0 + 8'(4 * i), 32'(p[i + 1]));
	endtask

	task automatic newsamples();
		for (int i = 0; i < NCH; i++) begin
			s[i] = 12'($random(seed)) & 12'h7FF;
			m.set_ch(i, s[i]);
		end
	endtask

	// watcher: the oldest expected read against the data phase
	always @(posedge sys_clk) begin
		if (rd_ph && hreadyout === 1'b1) begin
			ent = expq.pop_front();
			rdchk(hrdata & ent[31:0], ent[63:32] & ent[31:0]);
		end
	end

	initial begin
		repeat (5) @(posedge sys_clk);
		rstn <= 1'b1;
		newsamples();
		m.set_lvl(1'b0, 1'b0, 1'b1);
		@(posedge sys_clk);
		rd(A_CTRL, 32'(CTRL_RST));
		rd(A_SW_PERIOD, 32'(SW_PERIOD_RST));
		rd(A_OCP_THR, 32'(OCP_THR_RST));
		rd(A_IRQ_MASK, 32'h0);
		wr(8'h80, 32'hFFFF_FFFF);
		rd(8'h80, 32'h0);
		rdm(A_STATUS, ST_SON, 1'b1);
		// outside flag raises only the secondary power-good
		m.set_lvl(1'b0, 1'b1, 1'b1);
		poll(1, 1'b1, 20);
		chk(pg1_oe, 32'h0);
		rdm(A_STATUS, FL_EXT, 1'b1);
		m.set_lvl(1'b0, 1'b0, 1'b1);
		poll(1, 1'b0, 20);
		// each fault level in turn
		for (int b = 0; b < 7; b++) begin
			m.set_flt(7'h1 << b);
			poll(1, 1'b1, 20);
			chk(pg1_oe, 32'(b < 6));
			m.set_flt(7'h0);
			poll(1, 1'b0, 20);
		end
		// peak comparator on the primary current
		wr(A_OCP_THR, 32'h100);
		m.set_ch(CH_CS1, 12'h200);
		poll(0, 1'b1, 100);
		m.set_ch(CH_CS1, s[CH_CS1]);
		wr(A_OCP_THR, 32'(OCP_THR_RST));
		poll(0, 1'b0, 100);
		// both power-good rises have left their sticky event bits
		bus(1'b0, A_IRQ_STAT, 32'h0, (32'h1 << IRQ_PG1) | (32'h1 << IRQ_PG2),
			(32'h1 << IRQ_PG1) | (32'h1 << IRQ_PG2));
		// digital share levels and the secondary current range codes
		for (int k = 0; k < 4; k++) begin
			wr(A_CTRL, 32'h5 | (32'(k) << 3) | (32'(k % 2) << 1));
			if (k < 3) rng = 2'(k);
			poll(2, k % 2 == 0, 20);
			rdm(A_STATUS, ST_SHFB, k % 2 == 1);
			chk(cs2_range, rng);
		end
		// loop results once per switching period, source by mode
		wr(A_SW_PERIOD, 32'h28);
		poll(5, 1'b1, 300);
		poll(5, 1'b1, 300);
		chk(n, 32'h28);
		chk(loop_q.fast, s[CH_VS1F]);
		chk(loop_q.slow, s[CH_VS3]);
		chk(loop_q.src_local, 32'h0);
		m.set_lvl(1'b1, 1'b0, 1'b1);
		poll(5, 1'b1, 100);
		poll(5, 1'b1, 100);
		chk(loop_q.slow, s[CH_VS1]);
		chk(loop_q.src_local, 32'h1);
		m.set_lvl(1'b0, 1'b0, 1'b1);
		// masked window events keep the interrupt low
		repeat (2 * WC) @(posedge sys_clk);
		chk(irq, 32'h0);
		wr(A_IRQ_MASK, 32'h1 << IRQ_WIN);
		rdm(A_IRQ_STAT, IRQ_WIN, 1'b1);
		poll(3, 1'b1, 2 * WC);
		rdm(A_IRQ_STAT, IRQ_WIN, 1'b1);
		poll(3, 1'b0, 10);
		p = s;
		rdvals();
		newsamples();
		rdvals();
		repeat (2) begin
			poll(3, 1'b1, 2 * WC);
			rdm(A_IRQ_STAT, IRQ_WIN, 1'b1);
		end
		p = s;
		rdvals();
		// trims by bus and from nonvolatile memory
		v = 32'($random(seed)) & 32'hFFF;
		wr(A_TRIM0, v);
		rd(A_TRIM0, v);
		chk(nvm_trim.vs[0], v);
		nvm_trim_in <= {12'h2A5, 12'h0C3, 12'h7F1};
		nvm_load <= 1'b1;
		@(posedge sys_clk);
		nvm_load <= 1'b0;
		rd(A_TRIM0 + 8'h4, 32'h0C3);
		rd(A_TRIM0 + 8'h8, 32'h2A5);
		wr(A_CTRL, 32'h104);
		poll(4, 1'b1, 10);
		chk(hresp, 32'h0);
		conclude();
	end
endmodule
`default_nettype wire
